/* File: hw/tcf_capture_front.v */
// capture trigger front end: source select, noise canceller, edge select
`timescale 1ns/1ps
`include "tcf_consts.vh"

module tcf_capture_front #(
    parameter SAMPLES = `TCF_NC_SAMPLES
) (
    input wire pclk,
    input wire presetn,
    input wire capture_input_pin,
    input wire comparator_out,
    input wire comparator_capture_select,
    input wire noise_cancel,
    input wire rising_edge_sel,
    output reg capture_event
);

    reg [SAMPLES-1:0] history;
    reg filtered;
    reg level_prev;
    wire source;
    wire all_high;
    wire all_low;
    wire level_now;

    // comparator goes through the same filter and edge logic as the pin
    assign source = comparator_capture_select ? comparator_out
                                              : capture_input_pin;
    assign all_high = &history;
    assign all_low = ~|history;
    assign level_now = noise_cancel ? filtered : history[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            history <= {SAMPLES{1'b0}};
            filtered <= 1'b0;
            level_prev <= 1'b0;
            capture_event <= 1'b0;
        end else begin
            history <= {history[SAMPLES-2:0], source};
            // level moves only once every sample agrees
            if (all_high) begin
                filtered <= 1'b1;
            end else if (all_low) begin
                filtered <= 1'b0;
            end
            level_prev <= level_now;
            capture_event <= rising_edge_sel ? (level_now & ~level_prev)
                                             : (~level_now & level_prev);
        end
    end

endmodule

/* File: hw/tcf_consts.vh */
// constants for the sixteen-bit timer with capture and compare
`ifndef TCF_CONSTS_VH
`define TCF_CONSTS_VH

// register indices; byte address is four times the index
`define TCF_IDX_CTRL_A 8'h2F
`define TCF_IDX_FLAGS 8'h30
`define TCF_IDX_CTRL_B 8'h31
`define TCF_IDX_MASK 8'h32
`define TCF_IDX_COUNT16 8'h33
`define TCF_IDX_CMP_A 8'h34
`define TCF_IDX_CMP_B 8'h35
`define TCF_IDX_CAPTURE 8'h36
`define TCF_IDX_COUNT8 8'h37

// reset values
`define TCF_RST_CTRL_A 8'h00
`define TCF_RST_CTRL_B 8'h00
`define TCF_RST_MASK 8'h00

// flag and enable bit positions (mask uses the same positions)
`define TCF_BIT_CAPTURE 5
`define TCF_BIT_CMP_A 4
`define TCF_BIT_CMP_B 3
`define TCF_BIT_WIDE_OVF 2
`define TCF_BIT_RESERVED 1
`define TCF_BIT_NARROW_OVF 0

// control a fields
`define TCF_CA_MODE_A_HI 7
`define TCF_CA_MODE_A_LO 6
`define TCF_CA_MODE_B_HI 5
`define TCF_CA_MODE_B_LO 4
`define TCF_CA_PWM_HI 1
`define TCF_CA_PWM_LO 0
`define TCF_CA_WRITABLE 8'hF3

// control b fields
`define TCF_CB_RUN 0
`define TCF_CB_RISING 1
`define TCF_CB_NOISE_CANCEL 2
`define TCF_CB_CLEAR_ON_A 3
`define TCF_CB_COMPARATOR_SEL 4
`define TCF_CB_WRITABLE 8'h1F

// compare output modes
`define TCF_OUT_OFF 2'b00
`define TCF_OUT_TOGGLE 2'b01
`define TCF_OUT_CLEAR 2'b10
`define TCF_OUT_SET 2'b11

// pulse width select
`define TCF_PWM_OFF 2'b00
`define TCF_PWM_8 2'b01
`define TCF_PWM_9 2'b10
`define TCF_PWM_10 2'b11
`define TCF_TOP_8 16'h00FF
`define TCF_TOP_9 16'h01FF
`define TCF_TOP_10 16'h03FF

// noise canceller sample count
`define TCF_NC_SAMPLES 4

`endif

/* File: hw/tcf_timer.v */
// sixteen-bit timer with capture, two compares, pwm and shared flags
// Operation
// - capture event copies counter into capture register and sets flag bit 5.
// - flags clear when their vector executes or when software writes one.
// - capture request needs global enable, capture enable and capture flag.
// - counter equal to compare A sets flag bit 4.
// - counter equal to compare B sets flag bit 3.
// - compare requests gated by global enable, own enable and own flag.
// - sixteen-bit counter overflow sets flag bit 2.
// - in up/down pwm overflow flag sets when counter leaves zero.
// - eight-bit counter overflow sets flag bit 0.
// - overflow requests gated by global enable, own enable, own flag.
// - flag bit 1 is reserved and reads zero.
// - 8, 9 or 10-bit centred glitch-free pwm using both compares.
// - capture from pin with edge chosen in control b, or comparator.
// - noise canceller needs four equal samples before capture flag.
// - control a bits 7:6 choose compare A pin action; any mode but 00 enables the pin output.
// - control a bits 5:4 choose compare B pin action; any mode but 00 enables the pin output.
// - comparator capture uses the same filter and edge front end.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "tcf_consts.vh"

module tcf_timer #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire capture_input_pin,
    input wire comparator_out,
    input wire global_irq_enable,
    input wire [5:0] vector_taken,
    output wire [5:0] irq_request,
    output reg compare_a_out_pin,
    output wire compare_a_out_en,
    output reg compare_b_out_pin,
    output wire compare_b_out_en
);

    // valid flag positions; bit 1 never stores anything
    localparam [7:0] FLAG_MASK = 8'h3D;

    reg [7:0] timer16_control_a;
    reg [7:0] timer16_control_b;
    reg [7:0] irq_mask;
    reg [7:0] timer_interrupt_flags;
    reg [15:0] count16;
    reg [7:0] count8;
    reg [15:0] compare_a_value;
    reg [15:0] compare_b_value;
    reg [15:0] cmp_a_live;
    reg [15:0] cmp_b_live;
    reg [15:0] capture_value_reg;
    reg count_up;
    reg [15:0] next_count16;
    reg next_up;
    reg wide_ovf;
    reg [7:0] set_flags;
    reg [31:0] next_prdata;

    wire capture_event;
    wire run;
    wire [1:0] pwm_sel;
    wire pwm_on;
    wire [15:0] top;
    wire match_a;
    wire match_b;
    wire setup;
    wire access;
    wire [7:0] idx;
    wire mapped;
    wire wr;
    wire [7:0] wbyte0;
    wire [7:0] wbyte1;

    // register index from a word address; upper address bits must be zero
    function [7:0] reg_index;
        input [ADDR_WIDTH-1:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    function is_mapped;
        input [7:0] i;
        begin
            is_mapped = (i >= `TCF_IDX_CTRL_A) && (i <= `TCF_IDX_COUNT8);
        end
    endfunction

    // pin action on a match in normal mode
    function next_pin;
        input [1:0] mode;
        input pin;
        begin
            case (mode)
                `TCF_OUT_TOGGLE: next_pin = ~pin;
                `TCF_OUT_CLEAR: next_pin = 1'b0;
                `TCF_OUT_SET: next_pin = 1'b1;
                default: next_pin = pin;
            endcase
        end
    endfunction

    // centred pwm: non-inverted clears on the way up, sets on the way down
    function pwm_pin;
        input [1:0] mode;
        input up;
        input pin;
        begin
            case (mode)
                `TCF_OUT_CLEAR: pwm_pin = ~up;
                `TCF_OUT_SET: pwm_pin = up;
                default: pwm_pin = pin;
            endcase
        end
    endfunction

    tcf_capture_front #(
        .SAMPLES(`TCF_NC_SAMPLES)
    ) u_front (
        .pclk(pclk),
        .presetn(presetn),
        .capture_input_pin(capture_input_pin),
        .comparator_out(comparator_out),
        .comparator_capture_select(
            timer16_control_b[`TCF_CB_COMPARATOR_SEL]),
        .noise_cancel(timer16_control_b[`TCF_CB_NOISE_CANCEL]),
        .rising_edge_sel(timer16_control_b[`TCF_CB_RISING]),
        .capture_event(capture_event)
    );

    assign run = timer16_control_b[`TCF_CB_RUN];
    assign pwm_sel = timer16_control_a[`TCF_CA_PWM_HI:`TCF_CA_PWM_LO];
    assign pwm_on = (pwm_sel != `TCF_PWM_OFF);
    assign top = (pwm_sel == `TCF_PWM_8) ? `TCF_TOP_8 :
                 (pwm_sel == `TCF_PWM_9) ? `TCF_TOP_9 : `TCF_TOP_10;
    assign match_a = run && (count16 == cmp_a_live);
    assign match_b = run && (count16 == cmp_b_live);

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign idx = reg_index(paddr);
    assign mapped = is_mapped(idx) && (paddr[1:0] == 2'b00)
                    && (paddr[ADDR_WIDTH-1:10] == 0);
    assign wr = access && pwrite && mapped;
    assign wbyte0 = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign wbyte1 = pstrb[1] ? pwdata[15:8] : 8'h00;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    assign compare_a_out_en = timer16_control_a[`TCF_CA_MODE_A_HI:
                                                `TCF_CA_MODE_A_LO] != 2'b00;
    assign compare_b_out_en = timer16_control_a[`TCF_CA_MODE_B_HI:
                                                `TCF_CA_MODE_B_LO] != 2'b00;

    // requests: global enable, own enable and own flag all set
    assign irq_request = {6{global_irq_enable}} & irq_mask[5:0]
                         & timer_interrupt_flags[5:0];

    // counter next state
    always @* begin
        next_count16 = count16;
        next_up = count_up;
        wide_ovf = 1'b0;
        if (run) begin
            if (pwm_on) begin
                if (count_up) begin
                    if (count16 >= top) begin
                        next_up = 1'b0;
                        next_count16 = count16 - 16'h0001;
                    end else begin
                        next_count16 = count16 + 16'h0001;
                    end
                end else if (count16 == 16'h0000) begin
                    next_up = 1'b1;
                    next_count16 = 16'h0001;
                end else begin
                    next_count16 = count16 - 16'h0001;
                end
                // leaving zero counts as overflow here
                wide_ovf = (count16 == 16'h0000);
            end else begin
                next_up = 1'b1;
                if (match_a && timer16_control_b[`TCF_CB_CLEAR_ON_A]) begin
                    next_count16 = 16'h0000;
                end else begin
                    next_count16 = count16 + 16'h0001;
                end
                wide_ovf = (count16 == 16'hFFFF);
            end
        end
    end

    always @* begin
        set_flags = 8'h00;
        set_flags[`TCF_BIT_CAPTURE] = capture_event;
        set_flags[`TCF_BIT_CMP_A] = match_a;
        set_flags[`TCF_BIT_CMP_B] = match_b;
        set_flags[`TCF_BIT_WIDE_OVF] = wide_ovf;
        set_flags[`TCF_BIT_NARROW_OVF] = run && (count8 == 8'hFF);
    end

    always @* begin
        next_prdata = 32'h0000_0000;
        if (idx == `TCF_IDX_CTRL_A) begin
            next_prdata[7:0] = timer16_control_a;
        end else if (idx == `TCF_IDX_FLAGS) begin
            next_prdata[7:0] = timer_interrupt_flags & FLAG_MASK;
        end else if (idx == `TCF_IDX_CTRL_B) begin
            next_prdata[7:0] = timer16_control_b;
        end else if (idx == `TCF_IDX_MASK) begin
            next_prdata[7:0] = irq_mask;
        end else if (idx == `TCF_IDX_COUNT16) begin
            next_prdata[15:0] = count16;
        end else if (idx == `TCF_IDX_CMP_A) begin
            next_prdata[15:0] = compare_a_value;
        end else if (idx == `TCF_IDX_CMP_B) begin
            next_prdata[15:0] = compare_b_value;
        end else if (idx == `TCF_IDX_CAPTURE) begin
            next_prdata[15:0] = capture_value_reg;
        end else if (idx == `TCF_IDX_COUNT8) begin
            next_prdata[7:0] = count8;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite && mapped) begin
            prdata <= next_prdata;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
        end
    end

    // control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer16_control_a <= `TCF_RST_CTRL_A;
            timer16_control_b <= `TCF_RST_CTRL_B;
            irq_mask <= `TCF_RST_MASK;
            compare_a_value <= 16'h0000;
            compare_b_value <= 16'h0000;
        end else if (wr) begin
            if (idx == `TCF_IDX_CTRL_A && pstrb[0]) begin
                timer16_control_a <= pwdata[7:0] & `TCF_CA_WRITABLE;
            end else if (idx == `TCF_IDX_CTRL_B && pstrb[0]) begin
                timer16_control_b <= pwdata[7:0] & `TCF_CB_WRITABLE;
            end else if (idx == `TCF_IDX_MASK && pstrb[0]) begin
                irq_mask <= pwdata[7:0] & FLAG_MASK;
            end else if (idx == `TCF_IDX_CMP_A) begin
                if (pstrb[0]) compare_a_value[7:0] <= pwdata[7:0];
                if (pstrb[1]) compare_a_value[15:8] <= pwdata[15:8];
            end else if (idx == `TCF_IDX_CMP_B) begin
                if (pstrb[0]) compare_b_value[7:0] <= pwdata[7:0];
                if (pstrb[1]) compare_b_value[15:8] <= pwdata[15:8];
            end
        end
    end

    // flags: hardware set beats a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_interrupt_flags <= 8'h00;
        end else begin
            timer_interrupt_flags <= ((timer_interrupt_flags
                & ~{2'b00, vector_taken}
                & ~((wr && idx == `TCF_IDX_FLAGS) ? wbyte0 : 8'h00))
                | set_flags) & FLAG_MASK;
        end
    end

    // counters; a software write wins over counting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count16 <= 16'h0000;
            count8 <= 8'h00;
            count_up <= 1'b1;
        end else begin
            count_up <= next_up;
            if (wr && idx == `TCF_IDX_COUNT16) begin
                count16 <= {pstrb[1] ? pwdata[15:8] : count16[15:8],
                             pstrb[0] ? pwdata[7:0] : count16[7:0]};
            end else begin
                count16 <= next_count16;
            end
            if (wr && idx == `TCF_IDX_COUNT8 && pstrb[0]) begin
                count8 <= wbyte0;
            end else if (run) begin
                count8 <= count8 + 8'h01;
            end
        end
    end

    // capture copies the count seen when the edge is reported
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_reg <= 16'h0000;
        end else if (capture_event) begin
            capture_value_reg <= count16;
        end
    end

    // compare copies reload only at top in pwm so a period never glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_live <= 16'h0000;
            cmp_b_live <= 16'h0000;
        end else if (!pwm_on || (run && count_up && count16 >= top)) begin
            cmp_a_live <= compare_a_value;
            cmp_b_live <= compare_b_value;
        end
    end

    // compare output pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_out_pin <= 1'b0;
            compare_b_out_pin <= 1'b0;
        end else if (pwm_on) begin
            if (match_a) begin
                compare_a_out_pin <= pwm_pin(
                    timer16_control_a[7:6], count_up,
                    compare_a_out_pin);
            end
            if (match_b) begin
                compare_b_out_pin <= pwm_pin(
                    timer16_control_a[5:4], count_up,
                    compare_b_out_pin);
            end
        end else begin
            if (match_a) begin
                compare_a_out_pin <= next_pin(
                    timer16_control_a[7:6], compare_a_out_pin);
            end
            if (match_b) begin
                compare_b_out_pin <= next_pin(
                    timer16_control_a[5:4], compare_b_out_pin);
            end
        end
    end

endmodule

/* File: verif/tcf_far_side.sv */
// far side model: capture pin source and comparator output
`timescale 1ns/1ps

module tcf_far_side (
    input wire pclk,
    input wire compare_a_out_pin,
    input wire compare_b_out_pin,
    output reg capture_input_pin,
    output reg comparator_out
);
    initial begin
        capture_input_pin = 1'b0;
        comparator_out = 1'b0;
    end

    // driven levels; both sources idle low between events
    task automatic pulse(input bit from_cmp, input int len);
        @(posedge pclk);
        if (from_cmp) comparator_out <= 1'b1;
        else capture_input_pin <= 1'b1;
        repeat (len) @(posedge pclk);
        comparator_out <= 1'b0;
        capture_input_pin <= 1'b0;
    endtask
endmodule

/* File: verif/tcf_timer_props.sv */
// port-level checker for the sixteen-bit timer
`timescale 1ns/1ps
`include "tcf_consts.vh"

module tcf_timer_props #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire capture_input_pin,
    input wire comparator_out,
    input wire global_irq_enable,
    input wire [5:0] vector_taken,
    input wire [5:0] irq_request,
    input wire compare_a_out_pin,
    input wire compare_a_out_en,
    input wire compare_b_out_pin,
    input wire compare_b_out_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr_a = acc && pwrite && pstrb[0]
        && paddr == ADDR_WIDTH'({`TCF_IDX_CTRL_A, 2'b00});
    wire rd_f = acc && !pwrite
        && paddr == ADDR_WIDTH'({`TCF_IDX_FLAGS, 2'b00});

    property p_irq_global;
        !global_irq_enable |-> irq_request == 6'h00;
    endproperty
    a_irq_global: assert property (p_irq_global)
        else $error("request raised without global enable");
    property p_irq_reserved;
        irq_request[1] == 1'b0;
    endproperty
    a_irq_reserved: assert property (p_irq_reserved)
        else $error("reserved request bit set");
    property p_flag_bit1;
        rd_f |-> prdata[1] == 1'b0;
    endproperty
    a_flag_bit1: assert property (p_flag_bit1)
        else $error("reserved flag bit reads one");
    property p_slverr_zero;
        acc && !pwrite && pslverr |-> prdata == 32'h00000000;
    endproperty
    a_slverr_zero: assert property (p_slverr_zero)
        else $error("refused read returned data");
    property p_slverr_acc;
        pslverr |-> acc;
    endproperty
    a_slverr_acc: assert property (p_slverr_acc)
        else $error("error outside access phase");
    property p_en_a_wr;
        wr_a |=> compare_a_out_en == ($past(pwdata[7:6]) != 2'b00);
    endproperty
    a_en_a_wr: assert property (p_en_a_wr)
        else $error("pin a enable does not follow its mode");
    property p_en_b_wr;
        wr_a |=> compare_b_out_en == ($past(pwdata[5:4]) != 2'b00);
    endproperty
    a_en_b_wr: assert property (p_en_b_wr)
        else $error("pin b enable does not follow its mode");
    property p_en_a_hold;
        $changed(compare_a_out_en) |-> $past(wr_a);
    endproperty
    a_en_a_hold: assert property (p_en_a_hold)
        else $error("pin a enable moved without a write");
    property p_pin_a_still;
        !compare_a_out_en [*2] |=> $stable(compare_a_out_pin);
    endproperty
    a_pin_a_still: assert property (p_pin_a_still)
        else $error("disconnected pin a moved");
    property p_pin_b_still;
        !compare_b_out_en [*2] |=> $stable(compare_b_out_pin);
    endproperty
    a_pin_b_still: assert property (p_pin_b_still)
        else $error("disconnected pin b moved");

    c_capture_irq: cover property (irq_request[5]);
    c_flag_read: cover property (rd_f);
    c_pin_a_high: cover property (compare_a_out_en && compare_a_out_pin);
endmodule

bind tcf_timer tcf_timer_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
    .global_irq_enable(global_irq_enable), .vector_taken(vector_taken),
    .irq_request(irq_request), .compare_a_out_pin(compare_a_out_pin),
    .compare_a_out_en(compare_a_out_en),
    .compare_b_out_pin(compare_b_out_pin),
    .compare_b_out_en(compare_b_out_en)
);

/* File: verif/testbench.sv */
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ps
`include "tcf_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic global_irq_enable = 1'b0;
    logic [5:0] vector_taken = 6'h00;
    wire [31:0] prdata;
    wire pready, pslverr, capture_input_pin, comparator_out;
    wire [5:0] irq_request;
    wire compare_a_out_pin, compare_a_out_en;
    wire compare_b_out_pin, compare_b_out_en;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 50359;
    logic [31:0] rd;
    logic err;
    logic [15:0] v, top;
    logic [5:0] exp_flags;
    logic [15:0] cap_q [$];
    logic [7:0] cfg [4] = '{8'h02, 8'h10, 8'h06, 8'h06};
    bit src [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    int lens [4] = '{3, 3, 2, 6};
    bit hit [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

    tcf_timer u_tcf_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(capture_input_pin),
        .comparator_out(comparator_out),
        .global_irq_enable(global_irq_enable), .vector_taken(vector_taken),
        .irq_request(irq_request), .compare_a_out_pin(compare_a_out_pin),
        .compare_a_out_en(compare_a_out_en),
        .compare_b_out_pin(compare_b_out_pin),
        .compare_b_out_en(compare_b_out_en));
    tcf_far_side u_tcf_far_side (.pclk(pclk),
        .compare_a_out_pin(compare_a_out_pin),
        .compare_b_out_pin(compare_b_out_pin),
        .capture_input_pin(capture_input_pin),
        .comparator_out(comparator_out));

    always #50 pclk = ~pclk;

    task automatic give_verdict;
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one idle edge first, so psel is never assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [15:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [15:0] e);
        apb(1'b0, idx, 16'h0000);
        `CHK(rd[15:0], e)
    endtask

    initial begin
        #(100 * 20000);
        mismatches++;
        give_verdict;
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`TCF_IDX_CTRL_A, 16'h0000);
        rdc(`TCF_IDX_CTRL_B, 16'h0000);
        rdc(`TCF_IDX_MASK, 16'h0000);
        rdc(`TCF_IDX_FLAGS, 16'h0000);
        apb(1'b0, 8'h38, 16'h0000);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, `TCF_IDX_CTRL_A, 16'h00FF);
        rdc(`TCF_IDX_CTRL_A, 16'h00F3);
        apb(1'b1, `TCF_IDX_CTRL_A, 16'h0000);
        apb(1'b1, `TCF_IDX_CAPTURE, 16'h1234);
        rdc(`TCF_IDX_CAPTURE, 16'h0000);
        // both compares passed once while running
        v = $random(seed);
        apb(1'b1, `TCF_IDX_COUNT16, 16'h0010);
        apb(1'b1, `TCF_IDX_COUNT8, 16'h0000);
        apb(1'b1, `TCF_IDX_CMP_A, 16'h0014);
        apb(1'b1, `TCF_IDX_CMP_B, 16'h0011 + {12'h000, v[3:0]});
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0001);
        repeat (40) @(posedge pclk);
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0000);
        exp_flags = 6'h18;
        rdc(`TCF_IDX_FLAGS, {10'h000, exp_flags});
        apb(1'b1, `TCF_IDX_MASK, 16'h003F);
        for (int g = 0; g < 2; g++) begin
            global_irq_enable <= g[0];
            @(posedge pclk);
            #1 `CHK(irq_request, g ? exp_flags : 6'h00)
        end
        apb(1'b1, `TCF_IDX_FLAGS, 16'h0010);
        exp_flags = 6'h08;
        rdc(`TCF_IDX_FLAGS, {10'h000, exp_flags});
        vector_taken <= 6'h08;
        @(posedge pclk);
        vector_taken <= 6'h00;
        rdc(`TCF_IDX_FLAGS, 16'h0000);
        // both counters wrap
        apb(1'b1, `TCF_IDX_COUNT16, 16'hFFFE);
        apb(1'b1, `TCF_IDX_COUNT8, 16'h00FE);
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0001);
        repeat (4) @(posedge pclk);
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0000);
        rdc(`TCF_IDX_FLAGS, 16'h0005);
        `CHK(irq_request, 6'h05)
        apb(1'b1, `TCF_IDX_FLAGS, 16'h003F);
        // capture sources, edges and filter; counter held still
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            apb(1'b1, `TCF_IDX_COUNT16, v);
            // model: a counted event owes the held count to the capture
            if (hit[k]) cap_q.push_back(v);
            apb(1'b1, `TCF_IDX_CTRL_B, {8'h00, cfg[k]});
            u_tcf_far_side.pulse(src[k], lens[k]);
            repeat (12) @(posedge pclk);
            rdc(`TCF_IDX_FLAGS, hit[k] ? 16'h0020 : 16'h0000);
            if (hit[k]) rdc(`TCF_IDX_CAPTURE, cap_q.pop_front());
            apb(1'b1, `TCF_IDX_FLAGS, 16'h003F);
        end
        apb(1'b1, `TCF_IDX_CMP_A, 16'h0104);
        apb(1'b1, `TCF_IDX_CMP_B, 16'h0106);
        for (int j = 0; j < 3; j++) begin
            v = {8'h00, 2'(3 - j), 2'(3 - j), 4'h0};
            apb(1'b1, `TCF_IDX_CTRL_A, v);
            apb(1'b1, `TCF_IDX_COUNT16, 16'h0100);
            apb(1'b1, `TCF_IDX_CTRL_B, 16'h0001);
            repeat (20) @(posedge pclk);
            apb(1'b1, `TCF_IDX_CTRL_B, 16'h0000);
            `CHK({compare_a_out_pin, compare_b_out_pin}, {2{j != 1}})
        end
        apb(1'b1, `TCF_IDX_CTRL_A, 16'h0000);
        apb(1'b1, `TCF_IDX_CMP_A, 16'h0005);
        apb(1'b1, `TCF_IDX_COUNT16, 16'h0000);
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0009);
        repeat (30) @(posedge pclk);
        apb(1'b1, `TCF_IDX_CTRL_B, 16'h0000);
        apb(1'b0, `TCF_IDX_COUNT16, 16'h0000);
        `CHK(rd[15:0] <= 16'h0005, 1'b1)
        for (int k = 1; k < 4; k++) begin
            top = (16'h0080 << k) - 16'h0001;
            apb(1'b1, `TCF_IDX_COUNT16, 16'h0000);
            apb(1'b1, `TCF_IDX_FLAGS, 16'h003F);
            // pin a: mode 10 clears on the up-match at 5, mode 11 sets
            v = 16'(k) | (k[0] ? 16'h0080 : 16'h00C0);
            apb(1'b1, `TCF_IDX_CTRL_A, v);
            apb(1'b1, `TCF_IDX_CTRL_B, 16'h0001);
            repeat (int'(top) + 40) @(posedge pclk);
            apb(1'b1, `TCF_IDX_CTRL_B, 16'h0000);
            apb(1'b0, `TCF_IDX_COUNT16, 16'h0000);
            `CHK(rd[15:0] <= top, 1'b1)
            apb(1'b0, `TCF_IDX_FLAGS, 16'h0000);
            `CHK(rd[2], 1'b1)
            `CHK(compare_a_out_pin, !k[0])
        end
        apb(1'b1, `TCF_IDX_CTRL_A, 16'h0000);
        give_verdict;
    end
endmodule
